// ==== ahpc_top.sv ====
// Host parallel port and status pin logic of a 10-bit converter
`timescale 1ns/1ps
module ahpc_top
	import ahpc_pkg::*;
#(
	parameter int CLK_DIV   = AHPC_CLK_DIV,  // Fast clocks per conversion clock
	parameter int ACQ_CLKS  = AHPC_ACQ_CLKS, // Acquisition length
	parameter int CONV_CLKS = AHPC_CONV_CLKS // Conversion length
)(
	input  wire logic                mclk,          // System clock, 50 MHz
	input  wire logic                sys_rst,       // Synchronous reset, high
	input  wire logic                clk_en,        // Clock enable
	input  wire ahpc_pkg::ahpc_bus_t bus,           // Host bus pins in
	input  wire logic [9:0]          sample_a,      // First channel sample
	input  wire logic [9:0]          sample_b,      // Second channel sample
	output logic [9:0]               data_out,      // Data bus drive value
	output logic [9:0]               data_oe_n,     // Data bus enable, low drives
	output logic                     conversion_status_n, // Busy or interrupt, low
	output logic [9:0]               ctrl_word      // Control register value
);
	import ahpc_pkg::*;

	logic       rd_q;          // Read strobe, previous level
	logic       wr_q;          // Store strobe, previous level
	logic       wr_cs_q;       // Select held during store
	logic       rd_fall;       // Selected read falling edge
	logic       wr_fall;       // Selected store falling edge
	logic       wr_rise;       // Store rising edge while selected
	logic       start_q;       // Start pulse to sequencer
	logic       conv_active;   // Sequencer running
	logic       conv_done;     // Last conversion done
	logic [9:0] conv_result;   // Latest result
	logic       int_flag;      // Latched interrupt
	logic       status_mode;   // Status pin mode bit
	logic [9:0] next_data;     // Next data bus value
	logic       sel_read;      // Select and read asserted
	logic       next_mode;     // Mode bit after this edge

	assign status_mode = ctrl_word[AHPC_MODE_POS];
	// A store that changes mode steers the pin from the same edge
	assign next_mode   = wr_rise ? bus.din[AHPC_MODE_POS] : status_mode;
	assign sel_read    = !bus.cs_n && !bus.rd_n;
	assign rd_fall     = rd_q && !bus.rd_n && !bus.cs_n;
	assign wr_fall     = wr_q && !bus.wr_n && !bus.cs_n;
	assign wr_rise     = !wr_q && bus.wr_n && wr_cs_q;

	////////////////////////////////////////////////////////////////////
	// Strobe edge history
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rd_q    <= 1'b1;
			wr_q    <= 1'b1;
			wr_cs_q <= 1'b0;
		end
		else if (clk_en)
		begin
			rd_q    <= bus.rd_n;
			wr_q    <= bus.wr_n;
			wr_cs_q <= !bus.cs_n && !bus.wr_n;
		end
	end

	// Control register capture on store rising edge
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ctrl_word <= AHPC_CTRL_RST;
		else if (clk_en && wr_rise)
			ctrl_word <= bus.din;
	end

	// Start pulse follows the store edge
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			start_q <= 1'b0;
		else if (clk_en)
			start_q <= wr_rise;
	end

	ahpc_conv #(
		.CLK_DIV   (CLK_DIV),
		.ACQ_CLKS  (ACQ_CLKS),
		.CONV_CLKS (CONV_CLKS)
	) u_conv (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.start    (start_q),
		.dual     (ctrl_word[AHPC_DUAL_POS]),
		.sample_a (sample_a),
		.sample_b (sample_b),
		.active   (conv_active),
		.done     (conv_done),
		.result   (conv_result)
	);

	////////////////////////////////////////////////////////////////////
	// Interrupt latch; completion wins over a clearing edge
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			int_flag <= 1'b0;
		else if (clk_en)
		begin
			if (conv_done && status_mode)
				int_flag <= 1'b1;
			else if (rd_fall || wr_fall || !status_mode)
				int_flag <= 1'b0;
		end
	end

	// Status pin: busy or interrupt by mode
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			conversion_status_n <= 1'b1;
		else if (clk_en)
		begin
			if (!next_mode)
				conversion_status_n <= !(conv_active || start_q || wr_rise);
			else
				conversion_status_n <= !((conv_done || int_flag) && !(rd_fall || wr_fall)
					|| conv_done);
		end
	end

	// Data bus drive, enabled only on selected read
	always_comb
	begin
		next_data = conv_result;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			data_out  <= AHPC_MID_CODE;
			data_oe_n <= '1;
		end
		else if (clk_en)
		begin
			data_out  <= next_data;
			data_oe_n <= sel_read ? '0 : '1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	localparam int SGL_MAX = (AHPC_SINGLE_HALF * AHPC_CLK_DIV) / 2 + 8;
	localparam int DUL_MAX = (AHPC_DUAL_HALF * AHPC_CLK_DIV) / 2 + 8;

	sequence s_store_edge;
		wr_rise && clk_en;
	endsequence

	a_oe_needs_read: assert property (@(posedge mclk) disable iff (sys_rst)
		(data_oe_n == '0) |-> $past(sel_read))
		else $error("data driven without read and select");
	a_ctrl_capture: assert property (@(posedge mclk) disable iff (sys_rst)
		s_store_edge |=> (ctrl_word == $past(bus.din)))
		else $error("control word not captured");
	a_busy_on_start: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_store_edge and !bus.din[AHPC_MODE_POS]) |=> !conversion_status_n)
		else $error("busy not asserted on start");
	a_start_follows: assert property (@(posedge mclk) disable iff (sys_rst)
		s_store_edge |=> start_q)
		else $error("no start after store edge");
	a_single_time: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_store_edge and (!bus.din[AHPC_DUAL_POS] && CLK_DIV == AHPC_CLK_DIV
		&& ACQ_CLKS == AHPC_ACQ_CLKS && CONV_CLKS == AHPC_CONV_CLKS))
		|-> ##[1:SGL_MAX] conv_done)
		else $error("single conversion too slow");
	a_dual_time: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_store_edge and (bus.din[AHPC_DUAL_POS] && CLK_DIV == AHPC_CLK_DIV
		&& ACQ_CLKS == AHPC_ACQ_CLKS && CONV_CLKS == AHPC_CONV_CLKS))
		|-> ##[1:DUL_MAX] conv_done)
		else $error("dual conversion too slow");
	a_int_set: assert property (@(posedge mclk) disable iff (sys_rst)
		conv_done && clk_en && status_mode |=> !conversion_status_n && int_flag)
		else $error("interrupt not raised");
	a_int_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && next_mode && rd_fall && !conv_done |=> conversion_status_n)
		else $error("interrupt not cleared by read");
	a_busy_dual: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && !next_mode && conv_active |=> !conversion_status_n)
		else $error("busy released during conversion");
	a_ignore_unsel: assert property (@(posedge mclk) disable iff (sys_rst)
		bus.cs_n && !wr_cs_q |=> $stable(ctrl_word))
		else $error("write taken without select");
	// Bus port checks
	a_oe_release: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && !sel_read |=> (data_oe_n == '1))
		else $error("data bus not released");
	a_read_value: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && sel_read |=> (data_out == $past(conv_result)))
		else $error("read data not the result");
	// Status pin checks
	a_busy_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && !next_mode && !conv_active && !start_q && !wr_rise
		|=> conversion_status_n)
		else $error("busy held while idle");
	a_int_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && next_mode && int_flag && !rd_fall && !wr_fall
		|=> !conversion_status_n)
		else $error("interrupt dropped without clear");
endmodule // ahpc_top

// ==== ahpc_pkg.sv ====
// Shared constants and types for the converter host port control block
package ahpc_pkg;
	localparam int          AHPC_DATA_W        = 10;      // Parallel data port width
	localparam int          AHPC_MODE_POS      = 9;       // Status pin mode bit position
	localparam int          AHPC_DUAL_POS      = 6;       // Dual sample bit position
	localparam logic [9:0]  AHPC_CTRL_RST      = 10'h000; // Control register reset value
	localparam logic [9:0]  AHPC_MID_CODE      = 10'h000; // Twos complement midpoint code
	localparam int          AHPC_CLK_DIV       = 4;       // Fast clocks per conversion clock
	localparam int          AHPC_ACQ_CLKS      = 2;       // Conversion clocks to acquire
	localparam int          AHPC_CONV_CLKS     = 14;      // Conversion clocks per conversion
	localparam int          AHPC_SINGLE_HALF   = 39;      // Single limit, half periods (19.5)
	localparam int          AHPC_DUAL_HALF     = 67;      // Dual limit, half periods (33.5)
	localparam int          AHPC_MCLK_NS       = 20;      // Clock period in ns

	// Host bus pins as seen by the device
	typedef struct packed {
		logic       cs_n;   // Chip select, active low
		logic       rd_n;   // Read strobe, active low
		logic       wr_n;   // Store strobe, active low
		logic [9:0] din;    // Data bus level in
	} ahpc_bus_t;
endpackage

// ==== ahpc_conv.sv ====
// Conversion sequencer: acquisition then one or two conversions
`timescale 1ns/1ps
module ahpc_conv
	import ahpc_pkg::*;
#(
	parameter int CLK_DIV    = AHPC_CLK_DIV,   // Fast clocks per conversion clock
	parameter int ACQ_CLKS   = AHPC_ACQ_CLKS,  // Acquisition length
	parameter int CONV_CLKS  = AHPC_CONV_CLKS  // Conversion length
)(
	input  wire logic        mclk,       // System clock
	input  wire logic        sys_rst,    // Synchronous reset
	input  wire logic        clk_en,     // Clock enable
	input  wire logic        start,      // Start pulse
	input  wire logic        dual,       // Two conversions
	input  wire logic [9:0]  sample_a,   // First channel sample
	input  wire logic [9:0]  sample_b,   // Second channel sample
	output logic             active,     // Sequence running
	output logic             done,       // Final conversion done pulse
	output logic [9:0]       result      // Latest result
);
	typedef enum logic [1:0] {AHPC_IDLE, AHPC_ACQ, AHPC_CONV} ahpc_cst_t;
	ahpc_cst_t  state;         // Sequencer state
	logic [7:0] div_cnt;       // Conversion clock divider
	logic [7:0] step;          // Conversion clock count in phase
	logic       second;        // Second conversion in progress
	logic       tick;          // One conversion clock
	logic       acq_end;       // Acquisition finished
	logic       conv_end;      // Conversion finished
	logic [9:0] held_b;        // Second sample held at acquisition

	assign tick     = (div_cnt == 8'(CLK_DIV - 1));
	assign acq_end  = tick && (step == 8'(ACQ_CLKS - 1));
	assign conv_end = tick && (step == 8'(CONV_CLKS - 1));

	////////////////////////////////////////////////////////////////////
	// Divider restarts on start so timing is aligned to the strobe
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			div_cnt <= 8'h00;
		else if (clk_en)
			div_cnt <= (start || tick) ? 8'h00 : div_cnt + 8'h01;
	end

	// Sequencer
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state  <= AHPC_IDLE;
			step   <= 8'h00;
			second <= 1'b0;
			done   <= 1'b0;
			result <= AHPC_MID_CODE;
			held_b <= AHPC_MID_CODE;
		end
		else if (clk_en)
		begin
			done <= 1'b0;
			if (start)
			begin
				state  <= AHPC_ACQ;
				step   <= 8'h00;
				second <= 1'b0;
			end
			else
			begin
				case (state)
					AHPC_IDLE: step <= 8'h00;
					AHPC_ACQ:
					begin
						if (acq_end)
						begin
							state  <= AHPC_CONV;
							step   <= 8'h00;
							held_b <= sample_b;
						end
						else if (tick)
							step <= step + 8'h01;
					end
					AHPC_CONV:
					begin
						if (conv_end)
						begin
							step   <= 8'h00;
							result <= second ? held_b : sample_a;
							if (dual && !second)
								second <= 1'b1;
							else
							begin
								state <= AHPC_IDLE;
								done  <= 1'b1;
							end
						end
						else if (tick)
							step <= step + 8'h01;
					end
					default: state <= AHPC_IDLE;
				endcase
			end
		end
	end

	assign active = (state != AHPC_IDLE);
endmodule // ahpc_conv

// ==== ahpc_host_model.sv ====
// Host processor model that drives the converter bus
`timescale 1ns/1ps
module ahpc_host_model
	import ahpc_pkg::*;
(
	input  wire logic           mclk,      // System clock
	input  wire logic [9:0]     data_out,  // Device drive value
	input  wire logic [9:0]     data_oe_n, // Device enable, low drives
	output ahpc_pkg::ahpc_bus_t bus        // Bus pins to device
);
	logic       cs_n = 1;       // Select
	logic       rd_n = 1;       // Read strobe
	logic       wr_n = 1;       // Store strobe
	logic       drv = 0;        // Host drives data
	logic [9:0] hv = 10'h000;   // Host data
	logic [9:0] flt = 10'h155;  // Pattern on released lines
	////////////////////////////////////////////////////////////
	// Released lines change every cycle
	always @(posedge mclk)
		flt <= ~flt;
	// Each line resolved from both enables
	always_comb
	begin
		bus.cs_n = cs_n;
		bus.rd_n = rd_n;
		bus.wr_n = wr_n;
		for (int i = 0; i < 10; i++)
			bus.din[i] = !data_oe_n[i] ? data_out[i] : (drv ? hv[i] : flt[i]);
	end
	// Store cycle, data held past the rising strobe
	task automatic wr(input logic [9:0] v, input bit sel);
	begin
		@(negedge mclk);
		cs_n = !sel;
		wr_n = 0;
		drv = 1;
		hv = v;
		@(negedge mclk);
		wr_n = 1;
		@(negedge mclk);
		cs_n = 1;
		drv = 0;
	end
	endtask
	// Read cycle, strobe held until data shows
	task automatic rd(input bit sel);
	begin
		@(negedge mclk);
		cs_n = !sel;
		rd_n = 0;
		repeat (3) @(negedge mclk);
		cs_n = 1;
		rd_n = 1;
	end
	endtask
endmodule // ahpc_host_model

// ==== test_ahpc_top.sv ====
// Self-checking bench for the converter host port block
`timescale 1ns/1ps
module test_ahpc_top;
	import ahpc_pkg::*;
	logic        mclk = 0;         // System clock
	logic        sys_rst = 1;      // Reset, high
	logic [9:0]  sa = 10'h000;     // First sample
	logic [9:0]  sb = 10'h000;     // Second sample
	logic [9:0]  data_out;         // Drive value
	logic [9:0]  data_oe_n;        // Drive enable
	logic        stat_n;           // Status pin
	logic [9:0]  ctrl_word;        // Control register
	ahpc_bus_t   bus;              // Host bus
	logic [15:0] rng = 16'h5b4f;   // Random state
	logic [9:0]  expq[$];          // Expected read words
	int          failures = 0;     // Mismatches
	int          n_checks = 0;     // Comparisons
	int          cyc = 0;          // Cycle count
	bit          s1 = 0;           // Read selected last edge
	bit          s2 = 0;           // Read selected edge before
	bit          shown = 0;        // Word already taken
	logic [9:0]  modes[4] = '{10'h000, 10'h040, 10'h200, 10'h240}; // Control words
	////////////////////////////////////////////////////////////
	always #10 mclk = ~mclk;
	ahpc_top DUT (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .bus(bus),
		.sample_a(sa), .sample_b(sb), .data_out(data_out), .data_oe_n(data_oe_n),
		.conversion_status_n(stat_n), .ctrl_word(ctrl_word));
	ahpc_host_model u_host (.mclk(mclk), .data_out(data_out), .data_oe_n(data_oe_n),
		.bus(bus));
	////////////////////////////////////////////////////////////
	function automatic logic [15:0] xs(input logic [15:0] x);
		logic [15:0] y;
		y = x ^ (x << 7);
		y = y ^ (y >> 9);
		return y ^ (y << 8);
	endfunction
	task automatic chk(input bit ok, input string m);
	begin
		n_checks++;
		if (!ok)
		begin
			failures++;
			$display("unexpected at %0t: %s", $time, m);
		end
	end
	endtask
	task automatic test_done;
	begin
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	// Hang limit and read select history
	always @(posedge mclk)
	begin
		cyc++;
		s2 <= s1;
		s1 <= !bus.cs_n && !bus.rd_n;
		if (cyc == 5000)
		begin
			failures++;
			test_done();
		end
	end
	// Oldest note compared as each read word appears
	always @(negedge mclk)
	begin
		if (!(s1 || s2))
			chk(data_oe_n === 10'h3ff, "data driven outside read");
		else if (data_oe_n === 10'h000 && !shown)
		begin
			shown = 1;
			if (expq.size() == 0)
				chk(1'b0, "read with no note");
			else
				chk(data_out === expq.pop_front(), "read word");
		end
		if (data_oe_n === 10'h3ff)
			shown = 0;
	end
	// Each status mode and conversion length in turn
	initial
	begin
		int k;
		int lim;
		int lo;
		bit dual;
		bit intm;
		repeat (2) @(negedge mclk);
		sys_rst = 0;
		chk(ctrl_word === AHPC_CTRL_RST && stat_n === 1'b1, "reset values");
		foreach (modes[i])
		begin
			dual = modes[i][AHPC_DUAL_POS];
			intm = modes[i][AHPC_MODE_POS];
			rng = xs(rng);
			sa = rng[9:0];
			rng = xs(rng);
			sb = rng[9:0];
			lim = (dual ? AHPC_DUAL_HALF : AHPC_SINGLE_HALF) * AHPC_CLK_DIV / 2 + 4;
			lo = (AHPC_ACQ_CLKS + (dual ? 2 : 1) * AHPC_CONV_CLKS) * AHPC_CLK_DIV;
			u_host.wr(modes[i], 1'b1);
			@(negedge mclk);
			k = 2;
			chk(ctrl_word === modes[i], "control word");
			chk(stat_n === intm, "status at start");
			while (stat_n === intm && k < lim)
			begin
				@(negedge mclk);
				k++;
			end
			chk(stat_n === !intm && k >= lo && k < lim, "completion");
			expq.push_back(dual ? sb : sa);
			if (intm)
			begin
				repeat (4) @(negedge mclk);
				chk(stat_n === 1'b0, "interrupt not held");
				u_host.rd(1'b0);
				chk(stat_n === 1'b0, "unselected read cleared");
			end
			u_host.rd(1'b1);
			chk(stat_n === 1'b1, "status after read");
			$display("test ctrl %h done", modes[i]);
		end
		u_host.wr(10'h000, 1'b0);
		chk(ctrl_word === 10'h240 && stat_n === 1'b1, "unselected write");
		u_host.wr(10'h200, 1'b1);
		repeat (AHPC_SINGLE_HALF * AHPC_CLK_DIV / 2 + 4) @(negedge mclk);
		chk(stat_n === 1'b0, "single interrupt late");
		u_host.wr(10'h200, 1'b1);
		chk(stat_n === 1'b1, "store strobe clear");
		$display("test strobes done");
		test_done();
	end
endmodule // test_ahpc_top
